// ### hdl/flash_cmd_core.sv
// serial flash reset, status register write and discovery word handling
`timescale 1ns/100ps
`include "flash_cmd_defs.svh"
// Overview of operation
// RULE1 - reset only after 66h then 99h
// RULE2 - opcodes accepted on 1, 2 or 4 lanes
// RULE3 - host leaves 0-4-4 mode before reset
// RULE4 - status loads from non-volatile copy at power-up
// RULE5 - 06h enables non-volatile status write
// RULE6 - 50h enables volatile status override write
// RULE7 - no 4-byte entry, marked unsupported
// RULE8 - 4-byte exit field marked unsupported
// RULE9 - discovery word 16 is 80c030e8 at 6Ch
// RULE10 - 05h returns busy in bit zero
// RULE11 - other instruction between cancels armed reset
module flash_cmd_core (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  cs_n,
    input  wire logic                  sclk,
    input  wire logic [3:0]            io_in,
    output logic [3:0]                 io_out,
    output logic [3:0]                 io_oe,
    input  wire flash_cmd_pkg::lanes_e lane_mode,
    input  wire logic                  array_busy,
    output logic                       soft_reset_pulse,
    output logic [7:0]                 sr1_value,
    output logic                       write_enable_latch
);

    localparam flash_cmd_pkg::state_s RESET_STATE = '{
        s1: 6'h3f, s2: 6'h3f, s3: 6'h3f, filt: 6'h3f,
        phase: flash_cmd_pkg::PH_IDLE, bits: 4'h0, shin: 8'h00, opcode: 8'h00,
        abytes: 2'h0, addr: 24'h000000, dummy: 4'h0, wdata: 8'h00, wvalid: 1'b0,
        outsh: 8'h00, obits: 4'h0, op_exact: 1'b0, armed: 1'b0, wel: 1'b0,
        vol_arm: 1'b0, sr1: `NV_SR1_INIT, nv_sr1: `NV_SR1_INIT, soft_rst: 1'b0,
        io_out: 4'h0, io_oe: 4'h0};

    flash_cmd_pkg::state_s state_ff;
    flash_cmd_pkg::state_s nxt_state;

    //----------------------------------------------------------------
    // discovery byte fetch
    //----------------------------------------------------------------
    function automatic logic [7:0] disc_byte(input logic [23:0] a);
        logic [31:0] word;
        word = `DISC_WORD16;
        if (a[23:2] == `DISC_WORD16_ADDR >> 2) begin // see RULE9
            disc_byte = word[8 * a[1:0] +: 8];
        end else begin
            disc_byte = `DISC_FILL_BYTE;
        end
    endfunction : disc_byte

    logic [7:0] status_byte;
    logic [3:0] lane_w;
    logic [5:0] f;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic       cs_fall;
    logic [7:0] shifted;
    logic       byte_done;
    logic [7:0] obyte;
    logic [3:0] obits_sum;

    assign status_byte = {state_ff.sr1[7:2], state_ff.wel, array_busy}; // see RULE10

    //----------------------------------------------------------------
    // next state
    //----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.soft_rst = 1'b0;
        nxt_state.s1 = {cs_n, sclk, io_in};
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        for (int i = 0; i < 6; i++) begin
            f[i] = (state_ff.s2[i] == state_ff.s3[i]) ? state_ff.s3[i] : state_ff.filt[i];
        end
        nxt_state.filt = f;
        sclk_rise = !state_ff.filt[4] && f[4] && !f[5];
        sclk_fall = state_ff.filt[4] && !f[4] && !f[5];
        cs_rise   = !state_ff.filt[5] && f[5];
        cs_fall   = state_ff.filt[5] && !f[5];
        case (lane_mode) // see RULE2
            flash_cmd_pkg::LANES_2: begin
                lane_w  = 4'h2;
                shifted = {state_ff.shin[5:0], f[1:0]};
            end
            flash_cmd_pkg::LANES_4: begin
                lane_w  = 4'h4;
                shifted = {state_ff.shin[3:0], f[3:0]};
            end
            default: begin
                lane_w  = 4'h1;
                shifted = {state_ff.shin[6:0], f[0]};
            end
        endcase
        byte_done = (state_ff.bits + lane_w) == `BITS_PER_BYTE;
        obyte     = (state_ff.obits == 4'h0) ?
                    (state_ff.opcode == `OP_READ_STATUS1 ? status_byte
                                                         : disc_byte(state_ff.addr))
                    : state_ff.outsh;
        obits_sum = state_ff.obits + lane_w;

        if (cs_rise) begin
            // instructions take effect when the select rises
            nxt_state.phase = flash_cmd_pkg::PH_IDLE;
            nxt_state.io_oe = 4'h0;
            nxt_state.armed = 1'b0; // see RULE11
            if (state_ff.op_exact && state_ff.opcode == `OP_RESET_ENABLE) begin
                nxt_state.armed = 1'b1; // see RULE1
            end
            if (state_ff.op_exact && state_ff.opcode == `OP_RESET && state_ff.armed) begin
                nxt_state.soft_rst = 1'b1; // see RULE1
                nxt_state.wel      = 1'b0;
                nxt_state.vol_arm  = 1'b0;
                nxt_state.sr1      = state_ff.nv_sr1; // see RULE4
            end
            if (state_ff.op_exact && state_ff.opcode == `OP_WRITE_ENABLE) begin
                nxt_state.wel = 1'b1; // see RULE5
            end
            if (state_ff.op_exact && state_ff.opcode == `OP_VOL_SR_ENABLE) begin
                nxt_state.vol_arm = 1'b1; // see RULE6
            end
            if (state_ff.opcode == `OP_WRITE_STATUS && state_ff.wvalid) begin
                if (state_ff.vol_arm) begin
                    nxt_state.sr1     = state_ff.wdata; // see RULE6
                    nxt_state.vol_arm = 1'b0;
                end else if (state_ff.wel) begin
                    nxt_state.nv_sr1 = state_ff.wdata; // see RULE5
                    nxt_state.sr1    = state_ff.wdata;
                    nxt_state.wel    = 1'b0;
                end
            end
        end else if (cs_fall) begin
            nxt_state.phase    = flash_cmd_pkg::PH_OPCODE;
            nxt_state.bits     = 4'h0;
            nxt_state.op_exact = 1'b0;
            nxt_state.wvalid   = 1'b0;
            nxt_state.opcode   = 8'h00;
            nxt_state.obits    = 4'h0;
            nxt_state.abytes   = 2'h0;
            nxt_state.dummy    = 4'h0;
        end else if (sclk_rise) begin
            nxt_state.shin     = shifted;
            nxt_state.bits     = byte_done ? 4'h0 : state_ff.bits + lane_w;
            nxt_state.op_exact = 1'b0;
            case (state_ff.phase)
                flash_cmd_pkg::PH_OPCODE: begin
                    if (byte_done) begin
                        nxt_state.opcode   = shifted;
                        nxt_state.op_exact = 1'b1;
                        case (shifted)
                            `OP_WRITE_STATUS:   nxt_state.phase = flash_cmd_pkg::PH_WDATA;
                            `OP_READ_STATUS1:   nxt_state.phase = flash_cmd_pkg::PH_RDATA;
                            `OP_READ_DISCOVERY: nxt_state.phase = flash_cmd_pkg::PH_ADDR;
                            // 4-byte entry and exit opcodes fall here unserved
                            default: begin
                                nxt_state.phase = flash_cmd_pkg::PH_IDLE; // see RULE7, RULE8
                            end
                        endcase
                    end
                end
                flash_cmd_pkg::PH_ADDR: begin
                    if (byte_done) begin
                        nxt_state.addr   = {state_ff.addr[15:0], shifted};
                        nxt_state.abytes = state_ff.abytes + 2'h1;
                        if (state_ff.abytes == 2'h2) begin
                            nxt_state.phase = flash_cmd_pkg::PH_DUMMY;
                        end
                    end
                end
                flash_cmd_pkg::PH_DUMMY: begin
                    nxt_state.bits  = 4'h0;
                    nxt_state.dummy = state_ff.dummy + 4'h1;
                    if (state_ff.dummy == `DISC_DUMMY_CLKS - 4'h1) begin
                        nxt_state.phase = flash_cmd_pkg::PH_RDATA;
                    end
                end
                flash_cmd_pkg::PH_WDATA: begin
                    if (byte_done) begin
                        nxt_state.wdata  = shifted;
                        nxt_state.wvalid = 1'b1;
                        nxt_state.phase  = flash_cmd_pkg::PH_IDLE;
                    end
                end
                default: begin
                    nxt_state.bits = 4'h0;
                end
            endcase
        end else if (sclk_fall && state_ff.phase == flash_cmd_pkg::PH_RDATA) begin
            case (lane_mode)
                flash_cmd_pkg::LANES_2: begin
                    nxt_state.io_out = {2'h0, obyte[7:6]};
                    nxt_state.io_oe  = 4'h3;
                    nxt_state.outsh  = {obyte[5:0], 2'h0};
                end
                flash_cmd_pkg::LANES_4: begin
                    nxt_state.io_out = obyte[7:4];
                    nxt_state.io_oe  = 4'hf;
                    nxt_state.outsh  = {obyte[3:0], 4'h0};
                end
                default: begin
                    nxt_state.io_out = {2'h0, obyte[7], 1'b0};
                    nxt_state.io_oe  = 4'h2;
                    nxt_state.outsh  = {obyte[6:0], 1'b0};
                end
            endcase
            nxt_state.obits = (obits_sum == `BITS_PER_BYTE) ? 4'h0 : obits_sum;
            if (obits_sum == `BITS_PER_BYTE) begin
                nxt_state.addr = state_ff.addr + 24'h000001;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= RESET_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign io_out             = state_ff.io_out;
    assign io_oe              = state_ff.io_oe;
    assign soft_reset_pulse   = state_ff.soft_rst;
    assign sr1_value          = state_ff.sr1;
    assign write_enable_latch = state_ff.wel;

    //----------------------------------------------------------------
    // checks
    //----------------------------------------------------------------
    a_reset_needs_arm: assert property (@(posedge clock) disable iff (rst) // see RULE1
        $rose(state_ff.soft_rst) |-> $past(state_ff.armed)
                                      && $past(state_ff.opcode) == `OP_RESET)
        else $error("soft reset without armed 66h");
    a_reset_clears_wel: assert property (@(posedge clock) disable iff (rst) // see RULE1
        state_ff.soft_rst |-> !state_ff.wel && state_ff.sr1 == state_ff.nv_sr1)
        else $error("soft reset left write state");
    a_arm_cancelled: assert property (@(posedge clock) disable iff (rst) // see RULE11
        cs_rise && state_ff.opcode != `OP_RESET_ENABLE |=> !state_ff.armed)
        else $error("reset enable not cancelled");
    a_nv_needs_wel: assert property (@(posedge clock) disable iff (rst) // see RULE5
        state_ff.nv_sr1 != $past(state_ff.nv_sr1) |-> $past(state_ff.wel)
                                                     && !$past(state_ff.vol_arm))
        else $error("non-volatile write without 06h");
    a_vol_keeps_nv: assert property (@(posedge clock) disable iff (rst) // see RULE6
        cs_rise && state_ff.vol_arm && state_ff.wvalid
        && state_ff.opcode == `OP_WRITE_STATUS
        |=> state_ff.nv_sr1 == $past(state_ff.nv_sr1) && state_ff.sr1 == $past(state_ff.wdata))
        else $error("volatile write disturbed copy");
    a_sr_changes: assert property (@(posedge clock) disable iff (rst) // see RULE4
        state_ff.sr1 != $past(state_ff.sr1) |-> $past(cs_rise))
        else $error("status changed outside command end");
    a_no_four_byte: assert property (@(posedge clock) disable iff (rst) // see RULE7
        state_ff.op_exact && state_ff.opcode == 8'hb7 |-> state_ff.phase == flash_cmd_pkg::PH_IDLE)
        else $error("4-byte entry served");
    a_no_four_exit: assert property (@(posedge clock) disable iff (rst) // see RULE8
        state_ff.op_exact && state_ff.opcode == 8'he9 |-> state_ff.phase == flash_cmd_pkg::PH_IDLE)
        else $error("4-byte exit served");
    a_disc_word: assert property (@(posedge clock) disable iff (rst) // see RULE9
        disc_byte(`DISC_WORD16_ADDR) == 8'he8 && disc_byte(24'h00006f) == 8'h80)
        else $error("discovery word wrong");
    a_busy_bit: assert property (@(posedge clock) disable iff (rst) // see RULE10
        status_byte[0] == array_busy && status_byte[1] == state_ff.wel)
        else $error("status busy bit wrong");
    a_lane_oe: assert property (@(posedge clock) disable iff (rst) // see RULE2
        state_ff.io_oe != 4'h0 |-> state_ff.phase == flash_cmd_pkg::PH_RDATA)
        else $error("driving outside read data");
    c_soft_reset: cover property (@(posedge clock) disable iff (rst) $rose(state_ff.soft_rst));
    c_nv_write: cover property (@(posedge clock) disable iff (rst)
        state_ff.nv_sr1 != $past(state_ff.nv_sr1));
    c_vol_write: cover property (@(posedge clock) disable iff (rst)
        $fell(state_ff.vol_arm) && !state_ff.soft_rst);
    c_quad_read: cover property (@(posedge clock) disable iff (rst) state_ff.io_oe == 4'hf);

endmodule : flash_cmd_core

// ### inc/flash_cmd_defs.svh
// opcodes, discovery constants and reset values of the command interpreter
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99
`define OP_WRITE_ENABLE   8'h06
`define OP_VOL_SR_ENABLE  8'h50
`define OP_WRITE_STATUS   8'h01
`define OP_READ_STATUS1   8'h05
`define OP_READ_DISCOVERY 8'h5a

`define DISC_WORD16       32'h80c030e8
`define DISC_WORD16_ADDR  24'h00006c
`define DISC_FILL_BYTE    8'hff
`define DISC_DUMMY_CLKS   4'h8

`define NV_SR1_INIT       8'h00
`define BITS_PER_BYTE     4'h8

`endif

// ### inc/flash_cmd_pkg.sv
// types of the reset and status write command interpreter
package flash_cmd_pkg;

    typedef enum logic [1:0] {
        LANES_1 = 2'h0,
        LANES_2 = 2'h1,
        LANES_4 = 2'h2
    } lanes_e;

    typedef enum logic [5:0] {
        PH_IDLE   = 6'h01,
        PH_OPCODE = 6'h02,
        PH_ADDR   = 6'h04,
        PH_DUMMY  = 6'h08,
        PH_WDATA  = 6'h10,
        PH_RDATA  = 6'h20
    } phase_e;

    typedef struct packed {
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [5:0]  s3;
        logic [5:0]  filt;
        phase_e      phase;
        logic [3:0]  bits;
        logic [7:0]  shin;
        logic [7:0]  opcode;
        logic [1:0]  abytes;
        logic [23:0] addr;
        logic [3:0]  dummy;
        logic [7:0]  wdata;
        logic        wvalid;
        logic [7:0]  outsh;
        logic [3:0]  obits;
        logic        op_exact;
        logic        armed;
        logic        wel;
        logic        vol_arm;
        logic [7:0]  sr1;
        logic [7:0]  nv_sr1;
        logic        soft_rst;
        logic [3:0]  io_out;
        logic [3:0]  io_oe;
    } state_s;

endpackage : flash_cmd_pkg

// ### verif/flash_host_model.sv
// host side serial flash controller model
`timescale 1ns/100ps
module flash_host_model (
    input  wire logic                  clock,
    input  wire flash_cmd_pkg::lanes_e lane_mode,
    input  wire logic [3:0]            io_out,
    input  wire logic [3:0]            io_oe,
    output logic                       cs_n,
    output logic                       sclk,
    output logic [3:0]                 io_in
);
    logic [3:0] rd_oe;
    logic       sel;
    int         w;

    assign cs_n = ~sel;

    assign w = (lane_mode == flash_cmd_pkg::LANES_4) ? 4 :
               (lane_mode == flash_cmd_pkg::LANES_2) ? 2 : 1;

    initial begin
        sel = 1'b0;
        sclk = 1'b0;
        io_in = 4'h0;
        rd_oe = 4'h0;
    end

    task tick(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask : tick

    // never enters 0-4-4 continuous mode, so no exit step is needed
    task start();
        tick(1);
        sel = 1'b1;
    endtask : start

    // deselect; released lanes show the inverse of their last value
    task stop();
        tick(4);
        sel = 1'b0;
        io_in = ~io_in;
        tick(8);
    endtask : stop

    // msb first, lane width follows the current mode
    task send_byte(input logic [7:0] b);
        logic [7:0] sh;
        sh = b;
        for (int k = 0; k < 8 / w; k++) begin
            case (w)
                4: io_in = sh[7:4];
                2: io_in = {io_in[3:2], sh[7:6]};
                default: io_in = {io_in[3:1], sh[7]};
            endcase
            sh = sh << w;
            tick(4);
            sclk = ~sclk;
            tick(4);
            sclk = ~sclk;
        end
    endtask : send_byte

    // sampled late in the high phase, well after the fall that launched it
    task recv_byte(output logic [7:0] b);
        b = 8'h00;
        for (int k = 0; k < 8 / w; k++) begin
            io_in = ~io_in;
            tick(4);
            sclk = ~sclk;
            tick(3);
            rd_oe = io_oe;
            case (w)
                4: b = {b[3:0], io_out};
                2: b = {b[5:0], io_out[1:0]};
                default: b = {b[6:0], io_out[1]};
            endcase
            tick(1);
            sclk = ~sclk;
        end
    endtask : recv_byte
endmodule : flash_host_model

// ### verif/flash_reset_and_status_write_cmds_test.sv
// self-checking bench of the reset and status write command interpreter
`timescale 1ns/100ps
module flash_reset_and_status_write_cmds_test;
    logic                  clock;
    logic                  rst;
    logic                  array_busy;
    flash_cmd_pkg::lanes_e lane_mode;
    logic                  cs_n;
    logic                  sclk;
    logic [3:0]            io_in;
    logic [3:0]            io_out;
    logic [3:0]            io_oe;
    logic                  soft_reset_pulse;
    logic [7:0]            sr1_value;
    logic                  write_enable_latch;
    logic [7:0]            b;
    logic [31:0]           word;
    int                    err_total;
    int                    cmp_count;
    int                    pulses;

    flash_cmd_core dut (.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .lane_mode(lane_mode), .array_busy(array_busy),
        .soft_reset_pulse(soft_reset_pulse), .sr1_value(sr1_value),
        .write_enable_latch(write_enable_latch));
    flash_host_model host (.clock(clock), .lane_mode(lane_mode), .io_out(io_out),
        .io_oe(io_oe), .cs_n(cs_n), .sclk(sclk), .io_in(io_in));

    always #50 clock = ~clock;
    always @(posedge clock) if (soft_reset_pulse === 1'b1) pulses++;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task close_out();
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task cmd(input logic [7:0] op);
        host.start();
        host.send_byte(op);
        host.stop();
    endtask : cmd

    task wr_status(input logic [7:0] d);
        host.start();
        host.send_byte(8'h01);
        host.send_byte(d);
        host.stop();
    endtask : wr_status

    task rd_status(output logic [7:0] v);
        host.start();
        host.send_byte(8'h05);
        host.recv_byte(v);
        host.stop();
    endtask : rd_status

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_nv_write();
        check("sr1 after power-up", sr1_value, 8'h00);
        wr_status(8'h44);
        check("sr1 locked", sr1_value, 8'h00);
        cmd(8'h06);
        check("wel set", write_enable_latch, 1'b1);
        wr_status(8'h9c);
        check("sr1 nv", sr1_value, 8'h9c);
        check("wel consumed", write_enable_latch, 1'b0);
    endtask : t_nv_write

    task t_vol_write();
        cmd(8'h50);
        wr_status(8'h30);
        check("sr1 volatile", sr1_value, 8'h30);
        pulses = 0;
        cmd(8'h66);
        cmd(8'h99);
        check("reset pulses", pulses, 1);
        check("sr1 reload", sr1_value, 8'h9c);
    endtask : t_vol_write

    // broken sequences: other frame between, lone 99, extra clocks after 99
    task t_disarm();
        pulses = 0;
        cmd(8'h66);
        cmd(8'h05);
        cmd(8'h99);
        cmd(8'h99);
        cmd(8'h66);
        host.start();
        host.send_byte(8'h99);
        host.send_byte(8'h00);
        host.stop();
        check("no reset", pulses, 0);
    endtask : t_disarm

    task t_status();
        cmd(8'h06);
        array_busy = ~array_busy;
        rd_status(b);
        check("status busy", b, 8'h9f);
        check("read lane enable", host.rd_oe, 4'h2);
        array_busy = ~array_busy;
        rd_status(b);
        check("status ready", b, 8'h9e);
    endtask : t_status

    task t_lanes();
        pulses = 0;
        lane_mode = flash_cmd_pkg::LANES_2;
        cmd(8'h66);
        cmd(8'h99);
        check("wel after reset", write_enable_latch, 1'b0);
        rd_status(b);
        check("dual status", b, 8'h9c);
        check("dual lane enable", host.rd_oe, 4'h3);
        lane_mode = flash_cmd_pkg::LANES_4;
        cmd(8'h50);
        wr_status(8'h0c);
        check("sr1 quad write", sr1_value, 8'h0c);
        array_busy = ~array_busy;
        rd_status(b);
        array_busy = ~array_busy;
        check("quad status", b, 8'h0d);
        check("quad lane enable", host.rd_oe, 4'hf);
        cmd(8'h66);
        cmd(8'h99);
        lane_mode = flash_cmd_pkg::LANES_1;
        check("wide resets", pulses, 2);
        check("sr1 after wide reset", sr1_value, 8'h9c);
    endtask : t_lanes

    task t_discovery();
        cmd(8'hb7);
        cmd(8'he9);
        host.start();
        host.send_byte(8'h5a);
        host.send_byte(8'h00);
        host.send_byte(8'h00);
        host.send_byte(8'h6c);
        host.send_byte(8'hff);
        for (int i = 0; i < 4; i++) begin
            host.recv_byte(b);
            word = {b, word[31:8]};
        end
        host.stop();
        check("dword16", word, 32'h80c030e8);
        check("enter 4b field", word[31:24], 8'h80);
        check("exit 4b field", word[23:14], 10'h300);
        check("sr1 after b7", sr1_value, 8'h9c);
    endtask : t_discovery

    initial begin
        #2000000;
        err_total++;
        close_out();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        array_busy = 1'b0;
        lane_mode = flash_cmd_pkg::LANES_1;
        word = 32'h0;
        err_total = 0;
        cmp_count = 0;
        pulses = 0;
        repeat (2) @(posedge clock);
        #10;
        rst = 1'b0;
        host.tick(4);
        t_nv_write();
        t_vol_write();
        t_disarm();
        t_status();
        t_lanes();
        t_discovery();
        close_out();
    end
endmodule : flash_reset_and_status_write_cmds_test
